// ===== rtl/ors_pkg.sv
// constants for the octet receive silo block
// shared by the top module and the silo buffer
package ors_pkg;
    // register offsets within the octet (byte addresses)
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_LPAR = 3'h2;
    localparam logic [2:0] OFS_RXB = 3'h4;
    // receive buffer word fields
    localparam int RXB_DV = 15;
    localparam int RXB_OVR = 14;
    localparam int RXB_FERR = 13;
    localparam int RXB_PERR = 12;
    localparam int RXB_DSC = 11;
    localparam int RXB_LINE_LO = 8;
    localparam int ENTRY_W = 15;
    // line parameter fields
    localparam int LP_SEL_W = 3;
    localparam int LP_CLEN_LO = 3;
    localparam int LP_PEN = 5;
    localparam int LP_EVEN = 6;
    localparam int LP_STORE_W = 13;
    localparam int CLEN_BASE = 5;
    // character length codes
    localparam logic [1:0] CLEN_5 = 2'h0;
    localparam logic [1:0] CLEN_6 = 2'h1;
    localparam logic [1:0] CLEN_7 = 2'h2;
    localparam logic [1:0] CLEN_8 = 2'h3;
    // reset values and the alarm off value
    localparam logic [7:0] ALARM_RESET = 8'h01;
    localparam logic [2:0] PTR_RESET = 3'h0;
    localparam logic [7:0] ALARM_OFF = 8'h00;
    // timing and sizes
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int SILO_DEPTH = 64;
    localparam int NUM_LINES = 8;
endpackage

// ===== rtl/ors_silo_if.sv
// carrier between the top module and the silo buffer
// one clock domain, push and pop are single-cycle strobes
`timescale 1ns/1ps
interface ors_silo_if #(parameter int W = 15) ();
    logic push;
    logic pop;
    logic flush;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic empty;
    logic full;
    modport owner (output push, output pop, output flush, output wdata,
                   input rdata, input empty, input full);
    modport silo (input push, input pop, input flush, input wdata,
                  output rdata, output empty, output full);
endinterface

// ===== rtl/ors_silo.sv
// receive silo storage: first in, first out array of entries
// push when full is ignored; pop when empty is ignored
`timescale 1ns/1ps
module ors_silo #(
    parameter int DEPTH = ors_pkg::SILO_DEPTH,
    parameter int W = ors_pkg::ENTRY_W
) (
    input wire logic mclk,
    input wire logic resetn,
    ors_silo_if.silo sif
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] rd_ptr_q;
    logic [AW-1:0] wr_ptr_q;
    logic [AW:0] count_q;
    logic do_push;
    logic do_pop;

    assign do_push = sif.push && !sif.full;
    assign do_pop = sif.pop && !sif.empty;
    assign sif.empty = (count_q == '0);
    assign sif.full = (count_q == DEPTH_CNT);
    assign sif.rdata = sif.empty ? '0 : mem[rd_ptr_q];

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= sif.wdata;
        end
    end

    // pointers wrap at depth, so depth is a power of two
    always_ff @(posedge mclk) begin
        if (!resetn || sif.flush) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            case ({do_push, do_pop})
                2'b10: count_q <= count_q + 1'b1;
                2'b01: count_q <= count_q - 1'b1;
                default: count_q <= count_q;
            endcase
        end
    end
endmodule

// ===== rtl/ors_top.sv
// octet receive path: line parameters, popping receive silo, silo alarm
// host reaches registers over a 16-bit octet register port; receivers and
// modem logic on the same clock present characters and change notices
//
// Function
// [R1] char length code 00..11 selects five to eight data bits
// [R2] parameter write low three bits choose the line being stored
// [R3] parameter read returns line chosen by control register pointer
// [R4] each receive buffer read returns oldest entry and pops it
// [R5] silo holds characters with status and modem change notices
// [R6] reset or bus init empties the silo
// [R7] host must not use read-modify-write cycles on offset four
// [R8] top bit set while data present; other bits meaningful then
// [R9] valid flag clear after reset, init, or when silo empty
// [R10] overrun flag marks entries after characters lost to full silo
// [R11] framing error when first stop bit sampled at spacing level
// [R12] parity error when parity enabled and character parity wrong
// [R13] software trusts error flags only when change bit clear
// [R14] change entry: change flag set, byte zero, line number given
// [R15] every entry carries three-bit line number
// [R16] character right aligned, parity stripped, high bits zero
// [R17] alarm register shares offset four, word-written, low byte timeout
// [R18] interrupt when data sat in silo for programmed timeout
// [R19] alarm timer restarts on silo read, reset and init
// [R20] timeout zero disables the alarm
// [R21] timeout n gives about n milliseconds
// [R22] reset and init load the timeout with one
// [R23] reset and init clear the control register line pointer
// [R24] read of empty silo returns valid clear, restarts timer
// [R25] timer ticks only while silo holds data
`timescale 1ns/1ps
module ors_top #(
    parameter int DEPTH = ors_pkg::SILO_DEPTH,
    parameter int CYC_PER_MS = ors_pkg::CYC_PER_MS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic bus_init,
    input wire logic [2:0] bus_addr,
    input wire logic [1:0] bus_be,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic rx_char_valid,
    input wire logic [2:0] rx_char_line,
    input wire logic [8:0] rx_char_raw,
    input wire logic rx_stop_level,
    input wire logic dsc_valid,
    input wire logic [2:0] dsc_line,
    output logic alarm_irq
);
    localparam int NL = ors_pkg::NUM_LINES;
    localparam int PW = ors_pkg::LP_STORE_W;
    localparam int TW = $clog2(CYC_PER_MS);
    localparam logic [TW-1:0] TICK_LAST = TW'(CYC_PER_MS - 1);

    ors_silo_if #(.W(ors_pkg::ENTRY_W)) sif ();

    ors_silo #(
        .DEPTH(DEPTH),
        .W(ors_pkg::ENTRY_W)
    ) u_silo (
        .mclk(mclk),
        .resetn(resetn),
        .sif(sif.silo)
    );

    logic clr;
    logic sel_ctrl;
    logic sel_lpar;
    logic sel_rxb;
    logic word_wr;
    logic rxb_read;
    logic [2:0] line_ptr_q;
    logic [PW-1:0] lpar_q [NL];
    logic [7:0] alarm_timeout_q;
    logic [7:0] alarm_ms_q;
    logic [TW-1:0] tick_cnt_q;
    logic alarm_q;
    logic [NL-1:0] lost_q;
    logic [NL-1:0] dsc_pend_q;
    logic [15:0] rdata_q;
    logic rvalid_q;

    assign clr = !resetn || bus_init;
    assign sel_ctrl = (bus_addr == ors_pkg::OFS_CTRL);
    assign sel_lpar = (bus_addr == ors_pkg::OFS_LPAR);
    assign sel_rxb = (bus_addr == ors_pkg::OFS_RXB);
    assign word_wr = bus_wr && (bus_be == 2'h3);
    assign rxb_read = bus_rd && sel_rxb;

    // octet control register: only the line pointer lives here
    always_ff @(posedge mclk) begin
        if (clr) begin
            line_ptr_q <= ors_pkg::PTR_RESET; // R23
        end else if (bus_wr && sel_ctrl && bus_be[0]) begin
            line_ptr_q <= bus_wdata[2:0];
        end
    end

    // per-line parameter store, bits 15:3 of the written word
    genvar gl;
    generate
        for (gl = 0; gl < NL; gl++) begin : g_line
            logic hit;
            assign hit = bus_wr && sel_lpar && (bus_wdata[2:0] == 3'(gl)); // R2
            always_ff @(posedge mclk) begin
                if (clr) begin
                    lpar_q[gl] <= '0;
                end else if (hit) begin
                    if (bus_be[0]) begin
                        lpar_q[gl][4:0] <= bus_wdata[7:3];
                    end
                    if (bus_be[1]) begin
                        lpar_q[gl][PW-1:5] <= bus_wdata[15:8];
                    end
                end
            end
        end
    endgenerate

    // alarm timeout register, word writes only
    always_ff @(posedge mclk) begin
        if (clr) begin
            alarm_timeout_q <= ors_pkg::ALARM_RESET; // R22
        end else if (word_wr && sel_rxb) begin
            alarm_timeout_q <= bus_wdata[7:0]; // R17
        end
    end

    // ---- incoming character decode ----
    logic [PW-1:0] rx_par;
    logic [1:0] rx_clen;
    logic rx_pen;
    logic rx_even;
    logic [7:0] rx_mask;
    logic [7:0] rx_data;
    logic rx_pbit;
    logic rx_perr;
    logic rx_ferr;

    assign rx_par = lpar_q[rx_char_line];
    assign rx_clen = rx_par[ors_pkg::LP_CLEN_LO-3 +: 2];
    assign rx_pen = rx_par[ors_pkg::LP_PEN-3];
    assign rx_even = rx_par[ors_pkg::LP_EVEN-3];

    // data bit mask and parity bit position from length code
    always_comb begin
        rx_mask = 8'hff;
        rx_pbit = rx_char_raw[8];
        case (rx_clen)
            ors_pkg::CLEN_5: begin
                rx_mask = 8'h1f; // R1
                rx_pbit = rx_char_raw[5];
            end
            ors_pkg::CLEN_6: begin
                rx_mask = 8'h3f; // R1
                rx_pbit = rx_char_raw[6];
            end
            ors_pkg::CLEN_7: begin
                rx_mask = 8'h7f; // R1
                rx_pbit = rx_char_raw[7];
            end
            ors_pkg::CLEN_8: begin
                rx_mask = 8'hff; // R1
                rx_pbit = rx_char_raw[8];
            end
            default: begin
                rx_mask = 8'hff;
                rx_pbit = rx_char_raw[8];
            end
        endcase
    end

    assign rx_data = rx_char_raw[7:0] & rx_mask; // R16
    // odd parity: total ones odd; even parity: total ones even
    assign rx_perr = rx_pen && ((^{rx_data, rx_pbit}) == rx_even); // R12
    assign rx_ferr = !rx_stop_level; // R11

    // ---- silo fill ----
    logic char_push;
    logic char_lost;
    logic dsc_push;
    logic [2:0] dsc_sel;
    logic [ors_pkg::ENTRY_W-1:0] char_entry;
    logic [ors_pkg::ENTRY_W-1:0] dsc_entry;

    assign char_push = rx_char_valid && !sif.full;
    assign char_lost = rx_char_valid && sif.full;

    always_comb begin
        char_entry = '0;
        char_entry[ors_pkg::RXB_OVR] = lost_q[rx_char_line]; // R10
        char_entry[ors_pkg::RXB_FERR] = rx_ferr; // R11
        char_entry[ors_pkg::RXB_PERR] = rx_perr; // R12
        char_entry[ors_pkg::RXB_LINE_LO +: 3] = rx_char_line; // R15
        char_entry[7:0] = rx_data; // R16
    end

    // lowest pending modem line goes first
    always_comb begin
        dsc_sel = '0;
        for (int i = NL - 1; i >= 0; i--) begin
            if (dsc_pend_q[i]) begin
                dsc_sel = 3'(i);
            end
        end
    end

    // change notice waits while a character takes the slot or silo is full
    assign dsc_push = (dsc_pend_q != '0) && !rx_char_valid && !sif.full;

    always_comb begin
        dsc_entry = '0;
        dsc_entry[ors_pkg::RXB_DSC] = 1'b1; // R14
        dsc_entry[ors_pkg::RXB_LINE_LO +: 3] = dsc_sel; // R14
    end

    assign sif.push = char_push || dsc_push; // R5
    assign sif.wdata = char_push ? char_entry : dsc_entry; // R5
    assign sif.flush = bus_init; // R6
    assign sif.pop = rxb_read; // R4

    // per-line lost and pending flags; a new event wins over its clear
    generate
        for (gl = 0; gl < NL; gl++) begin : g_flag
            always_ff @(posedge mclk) begin
                if (clr) begin
                    lost_q[gl] <= 1'b0;
                end else if (char_lost && rx_char_line == 3'(gl)) begin
                    lost_q[gl] <= 1'b1; // R10
                end else if (char_push && rx_char_line == 3'(gl)) begin
                    lost_q[gl] <= 1'b0;
                end
            end
            always_ff @(posedge mclk) begin
                if (clr) begin
                    dsc_pend_q[gl] <= 1'b0;
                end else if (dsc_valid && dsc_line == 3'(gl)) begin
                    dsc_pend_q[gl] <= 1'b1;
                end else if (dsc_push && dsc_sel == 3'(gl)) begin
                    dsc_pend_q[gl] <= 1'b0;
                end
            end
        end
    endgenerate

    // ---- register read ----
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (sel_ctrl) begin
            rd_mux[2:0] = line_ptr_q;
        end else if (sel_lpar) begin
            rd_mux[15:3] = lpar_q[line_ptr_q]; // R3
        end else if (sel_rxb) begin
            rd_mux[ors_pkg::RXB_DV] = !sif.empty; // R8 R9 R24
            rd_mux[ors_pkg::ENTRY_W-1:0] = sif.rdata; // R4
        end
    end

    // read answer one cycle after the strobe, held until the next read, reset or init
    always_ff @(posedge mclk) begin
        if (clr) begin
            rdata_q <= '0;
        end else if (bus_rd) begin
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= bus_rd;
        end
    end

    assign bus_rdata = rdata_q;
    assign bus_rvalid = rvalid_q;

    // ---- silo alarm timer ----
    logic timer_restart;
    logic ms_tick;

    assign timer_restart = clr || rxb_read || sif.empty; // R19 R24 R25
    assign ms_tick = (tick_cnt_q == TICK_LAST);

    // millisecond prescaler, runs only while data waits
    always_ff @(posedge mclk) begin
        if (timer_restart) begin
            tick_cnt_q <= '0;
        end else if (ms_tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1; // R25
        end
    end

    // whole milliseconds waited, saturating
    always_ff @(posedge mclk) begin
        if (timer_restart) begin
            alarm_ms_q <= '0; // R19
        end else if (ms_tick && alarm_ms_q != 8'hff) begin
            alarm_ms_q <= alarm_ms_q + 8'h01; // R21
        end
    end

    // alarm level holds until read, reset or silo empties
    always_ff @(posedge mclk) begin
        if (timer_restart) begin
            alarm_q <= 1'b0;
        end else if (alarm_timeout_q != ors_pkg::ALARM_OFF && alarm_ms_q >= alarm_timeout_q) begin // R20
            alarm_q <= 1'b1; // R18 R21
        end
    end

    assign alarm_irq = alarm_q;
endmodule

// ===== dv/ors_top_props.sv
// port assertions for the octet receive block
// bound to ors_top from tb_top; single clock, sync active-low reset
`timescale 1ns/1ps
module ors_top_props #(
    parameter int DEPTH = 64,
    parameter int CYC_PER_MS = 10000
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic bus_init,
    input wire logic [2:0] bus_addr,
    input wire logic [1:0] bus_be,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rvalid,
    input wire logic alarm_irq
);
    logic [7:0] tmo_q;
    logic [31:0] wait_q;
    // mirror of the programmed timeout
    always_ff @(posedge mclk) begin
        if (!resetn || bus_init)
            tmo_q <= ors_pkg::ALARM_RESET;
        else if (bus_wr && bus_addr == ors_pkg::OFS_RXB && bus_be == 2'h3)
            tmo_q <= bus_wdata[7:0];
    end
    // cycles since the last reset, init or receive buffer read
    always_ff @(posedge mclk) begin
        if (!resetn || bus_init || (bus_rd && bus_addr == ors_pkg::OFS_RXB))
            wait_q <= 32'h0;
        else
            wait_q <= wait_q + 32'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_rvalid; bus_rd && !bus_init |=> bus_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    property p_no_rvalid; !bus_rd |=> !bus_rvalid; endproperty
    a_no_rvalid: assert property (p_no_rvalid) else $error("spurious read answer");
    property p_empty; bus_rvalid && $past(bus_addr) == ors_pkg::OFS_RXB && !bus_rdata[15] |-> bus_rdata == 16'h0;
    endproperty
    a_empty: assert property (p_empty) else $error("empty read not zero");
    property p_dsc; bus_rvalid && $past(bus_addr) == ors_pkg::OFS_RXB && bus_rdata[11] |-> bus_rdata[7:0] == 8'h0;
    endproperty
    a_dsc: assert property (p_dsc) else $error("change entry byte not zero");
    property p_lpar_low; bus_rvalid && $past(bus_addr) == ors_pkg::OFS_LPAR |-> bus_rdata[2:0] == 3'h0; endproperty
    a_lpar_low: assert property (p_lpar_low) else $error("parameter read low bits set");
    property p_init; bus_init && !bus_rd |=> bus_rdata == 16'h0 && !alarm_irq; endproperty
    a_init: assert property (p_init) else $error("init left state");
    property p_clear; bus_rd && bus_addr == ors_pkg::OFS_RXB |-> ##[1:2] !alarm_irq; endproperty
    a_clear: assert property (p_clear) else $error("alarm kept after read");
    property p_off; $rose(alarm_irq) |-> tmo_q != ors_pkg::ALARM_OFF; endproperty
    a_off: assert property (p_off) else $error("alarm with zero timeout");
    property p_period; $rose(alarm_irq) |-> wait_q >= tmo_q * CYC_PER_MS; endproperty
    a_period: assert property (p_period) else $error("alarm too early");
    property p_stand; alarm_irq && !bus_rd && !bus_init |=> alarm_irq; endproperty
    a_stand: assert property (p_stand) else $error("alarm dropped");
endmodule

// ===== dv/ors_host_model.sv
// host processor model on the octet register port
// strobes launched 1 ns after mclk rises; data released to its inverse
`timescale 1ns/1ps
module ors_host_model (
    input wire logic mclk,
    output logic [2:0] bus_addr,
    output logic [1:0] bus_be,
    output logic bus_rd,
    output logic bus_wr,
    output logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rvalid
);
    initial begin
        bus_addr = 3'h0;
        bus_be = 2'h0;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_wdata = 16'h0;
    end
    // plain write cycle, never read-modify-write
    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge mclk);
        #1;
        bus_addr = a;
        bus_be = be;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge mclk);
        #1;
        bus_wr = 1'b0;
        bus_wdata = ~d;
        bus_addr = ~a;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        int n;
        @(posedge mclk);
        #1;
        bus_addr = a;
        bus_be = 2'h3;
        bus_rd = 1'b1;
        @(posedge mclk);
        #1;
        bus_rd = 1'b0;
        bus_addr = ~a;
        n = 0;
        while (bus_rvalid !== 1'b1 && n < 8) begin
            @(posedge mclk);
            #1;
            n++;
        end
        d = (bus_rvalid === 1'b1) ? bus_rdata : 16'hxxxx;
    endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the octet receive block
// host model drives registers; bench drives receivers and modem notices
`timescale 1ns/1ps
module tb_top;
    localparam int CPM = 8;
    typedef struct {logic [15:0] lpar; logic [8:0] raw; logic stop; logic [15:0] exp;} ors_row_t;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic bus_init = 1'b0;
    logic [2:0] bus_addr;
    logic [1:0] bus_be;
    logic bus_rd;
    logic bus_wr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic bus_rvalid;
    logic rx_char_valid = 1'b0;
    logic [2:0] rx_char_line = 3'h0;
    logic [8:0] rx_char_raw = 9'h0;
    logic rx_stop_level = 1'b1;
    logic dsc_valid = 1'b0;
    logic [2:0] dsc_line = 3'h0;
    logic alarm_irq;
    logic [15:0] got;
    int n;
    int n_fail = 0;
    int tests_run = 0;
    ors_row_t rows [4] = '{'{16'h0000, 9'h1ff, 1'b1, 16'h801f}, '{16'h0069, 9'h03f, 1'b1, 16'h813f},
        '{16'h0032, 9'h081, 1'b1, 16'h9201}, '{16'h001b, 9'h1a5, 1'b0, 16'ha3a5}};
    always #50 mclk = ~mclk;
    ors_top #(.DEPTH(4), .CYC_PER_MS(CPM)) dut_u (.mclk(mclk), .resetn(resetn), .bus_init(bus_init),
        .bus_addr(bus_addr), .bus_be(bus_be), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .rx_char_valid(rx_char_valid),
        .rx_char_line(rx_char_line), .rx_char_raw(rx_char_raw), .rx_stop_level(rx_stop_level),
        .dsc_valid(dsc_valid), .dsc_line(dsc_line), .alarm_irq(alarm_irq));
    ors_host_model host_u (.mclk(mclk), .bus_addr(bus_addr), .bus_be(bus_be), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic push(input logic [2:0] l, input logic [8:0] raw, input logic stop, input logic dsc);
        @(posedge mclk);
        #1;
        rx_char_valid = 1'b1;
        rx_char_line = l;
        rx_char_raw = raw;
        rx_stop_level = stop;
        dsc_valid = dsc;
        dsc_line = 3'h5;
        @(posedge mclk);
        #1;
        rx_char_valid = 1'b0;
        dsc_valid = 1'b0;
        rx_char_raw = ~raw;
        rx_char_line = ~l;
    endtask
    task automatic alarm_wait(input int lim);
        n = 0;
        while (alarm_irq !== 1'b1 && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        n_fail++;
        $display("wrong value at %0t: watchdog expired", $time);
        test_done();
    end
    initial begin
        repeat (2) @(posedge mclk);
        #1;
        resetn = 1'b1;
        foreach (rows[i]) begin
            host_u.wr(ors_pkg::OFS_LPAR, rows[i].lpar, 2'h3);
            host_u.wr(ors_pkg::OFS_CTRL, {13'h0, rows[i].lpar[2:0]}, 2'h3);
            host_u.rd(ors_pkg::OFS_LPAR, got);
            check(got, rows[i].lpar & 16'hfff8);
            push(rows[i].lpar[2:0], rows[i].raw, rows[i].stop, 1'b0);
            host_u.rd(ors_pkg::OFS_RXB, got);
            check(got, rows[i].exp);
            $display("row %0d done", i);
        end
        push(3'h0, 9'h003, 1'b1, 1'b0);
        push(3'h6, 9'h004, 1'b1, 1'b1);
        repeat (3) @(posedge mclk);
        foreach (rows[i]) begin
            host_u.rd(ors_pkg::OFS_RXB, got);
            check(got, i == 0 ? 16'h8003 : i == 1 ? 16'h8604 : i == 2 ? 16'h8d00 : 16'h0);
        end
        $display("order and change notice done");
        for (int k = 0; k < 5; k++) push(3'h4, 9'(k), 1'b1, 1'b0);
        for (int k = 0; k < 4; k++) begin
            host_u.rd(ors_pkg::OFS_RXB, got);
            check(got, 16'h8400 | 16'(k));
        end
        push(3'h4, 9'h007, 1'b1, 1'b0);
        host_u.rd(ors_pkg::OFS_RXB, got);
        check(got, 16'hc407);
        $display("overrun done");
        host_u.wr(ors_pkg::OFS_RXB, 16'h00ff, 2'h1);
        for (int k = 1; k <= 3; k += 2) begin
            if (k > 1) host_u.wr(ors_pkg::OFS_RXB, 16'(k), 2'h3);
            push(3'h7, 9'h011, 1'b1, 1'b0);
            alarm_wait(8 * CPM);
            check(16'(n >= k * CPM - 1 && n <= k * CPM + 4), 16'h1);
            host_u.rd(ors_pkg::OFS_RXB, got);
            check(got, 16'h8711);
            check({15'h0, alarm_irq}, 16'h0);
        end
        host_u.wr(ors_pkg::OFS_RXB, 16'hff00, 2'h3);
        push(3'h7, 9'h011, 1'b1, 1'b0);
        alarm_wait(4 * CPM);
        check({15'h0, alarm_irq}, 16'h0);
        $display("alarm done");
        host_u.wr(ors_pkg::OFS_CTRL, 16'h0003, 2'h3);
        @(posedge mclk);
        #1;
        bus_init = 1'b1;
        @(posedge mclk);
        #1;
        bus_init = 1'b0;
        host_u.rd(ors_pkg::OFS_CTRL, got);
        check(got, 16'h0);
        host_u.rd(ors_pkg::OFS_RXB, got);
        check(got, 16'h0);
        push(3'h7, 9'h011, 1'b1, 1'b0);
        alarm_wait(8 * CPM);
        check(16'(n >= CPM - 1 && n <= CPM + 4), 16'h1);
        host_u.rd(3'h6, got);
        check(got, 16'h0);
        host_u.rd(ors_pkg::OFS_RXB, got);
        check(got, 16'h8711);
        host_u.wr(ors_pkg::OFS_LPAR, 16'hf0fd, 2'h2);
        host_u.wr(ors_pkg::OFS_CTRL, 16'h0005, 2'h3);
        host_u.rd(ors_pkg::OFS_LPAR, got);
        check(got, 16'hf000);
        $display("init done");
        test_done();
    end
endmodule
bind ors_top ors_top_props #(.DEPTH(DEPTH), .CYC_PER_MS(CYC_PER_MS)) props_u (.mclk(mclk), .resetn(resetn),
    .bus_init(bus_init), .bus_addr(bus_addr), .bus_be(bus_be), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .alarm_irq(alarm_irq));
